// file: design/rxp_pkg.sv
// Constants for the receive FIFO and preamble qualifier block.
// Assumes one 200 MHz clock and an SPI master on the register pins.
//
// Overview of operation
// RQ1: Received bytes are held in a 64-byte FIFO and a burst read of address 7Fh returns them in turn.
// RQ2: The FIFO fill level is compared with the six-bit almost-full threshold and an interrupt is raised when it is reached.
// RQ3: After an almost-full interrupt the host drains the received bytes from the FIFO.
// RQ4: Setting the FIFO clear bit in register 08h resets only the read and write pointers and leaves the data in place.
// RQ5: An event drives the interrupt pin only when enabled in 05h or 06h, while its status bit is always reported.
// RQ6: A valid preamble is declared only after the threshold in register 35h of consecutive valid preamble bits.
// RQ7: Host software should program a threshold of 20 when the transmitted preamble is longer than 32 bits.
// RQ8: The transmitter should send a preamble sized to the threshold and modulation, shorter where errors are tolerable.
// RQ9: An invalid-preamble indication is asserted when no valid preamble is found within the time set by 60h bits 7:4.
// RQ10: The invalid-preamble window lasts the four-bit time field times 4 data bit periods.
// RQ11: Preamble-detected and invalid-preamble events are reported as bits in status registers 03h and 04h; the code sets both only in 04h.
// RQ12: Any reset returns every register to its default value.
// RQ13: A software reset through register 08h holds the internal reset for between 50 and 470 microseconds.
// RQ14: The sync-word detector stays disabled until a valid preamble has been declared.
// RQ15: The write pointer advances once per stored byte and the read pointer once per byte returned by a burst read.
package rxp_pkg;
	localparam int          CLK_PERIOD_NS   = 5;
	localparam int          SWRST_MIN_US    = 50;
	localparam int          SWRST_MIN_CYC   = (SWRST_MIN_US * 1000 + CLK_PERIOD_NS - 1)
	                                          / CLK_PERIOD_NS;
	localparam int          FIFO_DEPTH      = 64;
	localparam int          FIFO_WIDTH      = 8;

	localparam logic [6:0]  ADDR_STATUS_ONE = 7'h03;
	localparam logic [6:0]  ADDR_STATUS_TWO = 7'h04;
	localparam logic [6:0]  ADDR_ENABLE_ONE = 7'h05;
	localparam logic [6:0]  ADDR_ENABLE_TWO = 7'h06;
	localparam logic [6:0]  ADDR_OPFUNC_TWO = 7'h08;
	localparam logic [6:0]  ADDR_PRE_THR    = 7'h35;
	localparam logic [6:0]  ADDR_INV_TIME   = 7'h60;
	localparam logic [6:0]  ADDR_FIFO_CTL   = 7'h7e;
	localparam logic [6:0]  ADDR_FIFO_PORT  = 7'h7f;

	localparam logic [7:0]  ENABLE_RST      = 8'h00;
	localparam logic [7:0]  OPFUNC_RST      = 8'h00;
	localparam logic [7:0]  PRE_THR_RST     = 8'h14;
	localparam logic [7:0]  INV_TIME_RST    = 8'h00;
	localparam logic [7:0]  FIFO_CTL_RST    = 8'h37;
	localparam logic [7:0]  OPFUNC_MASK     = 8'h16;
	localparam logic [7:0]  FIFO_CTL_MASK   = 8'h3f;

	localparam int          BIT_SWRST       = 7;
	localparam int          BIT_FFCLR       = 1;
	localparam int          BIT_ALMOST_FULL = 4;
	localparam int          BIT_PRE_VALID   = 6;
	localparam int          BIT_PRE_INVALID = 5;
endpackage

// file: design/rxp_fifo.sv
// Byte FIFO with pointer clear that keeps the stored bytes.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/10ps
module rxp_fifo
	import rxp_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int WIDTH = FIFO_WIDTH,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clr,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head_data,
	output logic      [AW:0]      level,
	output logic                  full,
	output logic                  empty
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wptr;
		logic [AW-1:0]               rptr;
		logic [AW:0]                 cnt;
	} rxp_fifo_state_type;

	rxp_fifo_state_type q_r;
	rxp_fifo_state_type q_nxt;

	logic do_push;
	logic do_pop;

	assign full      = (q_r.cnt == (AW+1)'(DEPTH));
	assign empty     = (q_r.cnt == '0);
	assign level     = q_r.cnt;
	assign head_data = q_r.mem[q_r.rptr];

	always_comb begin
		q_nxt   = q_r;
		do_push = push && !full;
		do_pop  = pop && !empty;
		if (do_push) begin
			q_nxt.mem[q_r.wptr] = push_data;
			q_nxt.wptr          = q_r.wptr + 1'b1; // [RQ15]
		end
		if (do_pop) begin
			q_nxt.rptr = q_r.rptr + 1'b1; // [RQ15]
		end
		q_nxt.cnt = q_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
		if (clr) begin
			// Only the pointers and the count are cleared; the array keeps its contents.
			q_nxt.wptr = '0; // [RQ4]
			q_nxt.rptr = '0;
			q_nxt.cnt  = '0;
			q_nxt.mem  = q_r.mem;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	a_clr_keeps_data: assert property (@(posedge clk) disable iff (!rst_n)
		clr |=> (q_r.mem == $past(q_r.mem)) && (q_r.cnt == 0)) // [RQ4]
		else $error("FIFO clear changed stored data or left a count.");
	a_push_once: assert property (@(posedge clk) disable iff (!rst_n)
		(push && !full && !pop && !clr) |=> q_r.cnt == $past(q_r.cnt) + 1) // [RQ15]
		else $error("Stored byte did not advance the count by one.");
endmodule

// file: design/rxp_rx_fifo_preamble.sv
// Receive FIFO, preamble qualifier and SPI register slave.
// Assumes SPI mode 0, MSB first, SCLK well below a quarter of clk; demodulator on clk.
`timescale 1ns/10ps
module rxp_rx_fifo_preamble
	import rxp_pkg::*;
#(
	parameter int SWRST_CYCLES = SWRST_MIN_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       spi_sclk,
	input  wire logic       spi_nsel,
	input  wire logic       spi_sdi,
	output logic            spi_sdo,
	input  wire logic       rx_bit_tick,
	input  wire logic       rx_preamble_bit,
	input  wire logic       rx_search_restart,
	input  wire logic       rx_byte_valid,
	input  wire logic [7:0] rx_byte,
	output logic            interrupt_request_pin_n,
	output logic            sync_detect_en,
	output logic            preamble_valid,
	output logic            invalid_preamble,
	output logic            soft_reset_active
);
	typedef struct packed {
		logic [2:0]  sclk_s;
		logic [2:0]  nsel_s;
		logic [1:0]  sdi_s;
		logic [7:0]  shreg;
		logic [2:0]  bitc;
		logic        data_ph;
		logic        wr;
		logic [6:0]  addr;
		logic [7:0]  out_sh;
		logic        port_ok;
		logic [7:0]  st1;
		logic [7:0]  st2;
		logic [7:0]  en1;
		logic [7:0]  en2;
		logic [7:0]  ctl2;
		logic [7:0]  pre_thr;
		logic [7:0]  inv_time;
		logic [7:0]  fifo_ctl;
		logic [7:0]  pre_run;
		logic [5:0]  inv_cnt;
		logic        pre_valid;
		logic        pre_invalid;
		logic [15:0] swrst_cnt;
	} rxp_state_type;

	rxp_state_type q_r;
	rxp_state_type q_nxt;

	logic [7:0] fifo_head;
	logic [6:0] fifo_level;
	logic       fifo_full;
	logic       fifo_empty;
	logic       fifo_pop;
	logic       fifo_clr;

	function automatic logic [7:0] reg_rd(input logic [6:0] a, input rxp_state_type s,
	                                      input logic [7:0] head);
		case (a)
			ADDR_STATUS_ONE: reg_rd = s.st1;
			ADDR_STATUS_TWO: reg_rd = s.st2;
			ADDR_ENABLE_ONE: reg_rd = s.en1;
			ADDR_ENABLE_TWO: reg_rd = s.en2;
			ADDR_OPFUNC_TWO: reg_rd = s.ctl2;
			ADDR_PRE_THR:    reg_rd = s.pre_thr;
			ADDR_INV_TIME:   reg_rd = s.inv_time;
			ADDR_FIFO_CTL:   reg_rd = s.fifo_ctl;
			ADDR_FIFO_PORT:  reg_rd = head;
			default:         reg_rd = 8'h00;
		endcase
	endfunction

	rxp_fifo #(
		.DEPTH (FIFO_DEPTH),
		.WIDTH (FIFO_WIDTH),
		.AW    (6)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.clr       (fifo_clr),
		.push      (rx_byte_valid),
		.push_data (rx_byte),
		.pop       (fifo_pop),
		.head_data (fifo_head),
		.level     (fifo_level),
		.full      (fifo_full),
		.empty     (fifo_empty)
	);

	assign fifo_clr = q_r.ctl2[BIT_FFCLR] || (q_r.swrst_cnt != '0); // [RQ4] [RQ12]

	always_comb begin
		logic [7:0] byte_in;
		logic       rise;
		logic       rd_clr1;
		logic       rd_clr2;
		logic [7:0] set1;
		logic [7:0] set2;
		logic [6:0] nxt_addr;
		logic [5:0] win;
		byte_in  = '0;
		rise     = 1'b0;
		rd_clr1  = 1'b0;
		rd_clr2  = 1'b0;
		set1     = '0;
		set2     = '0;
		nxt_addr = '0;
		win      = {q_r.inv_time[7:4], 2'b00}; // [RQ10]
		fifo_pop = 1'b0;
		q_nxt    = q_r;
		// Stage 0 feeds stage 1 only; edges are seen between stages 1 and 2.
		q_nxt.sclk_s = {q_r.sclk_s[1:0], spi_sclk};
		q_nxt.nsel_s = {q_r.nsel_s[1:0], spi_nsel};
		q_nxt.sdi_s  = {q_r.sdi_s[0], spi_sdi};
		rise         = q_r.sclk_s[1] && !q_r.sclk_s[2];

		if (q_r.nsel_s[1]) begin
			q_nxt.bitc    = '0;
			q_nxt.data_ph = 1'b0;
		end else if (rise) begin
			byte_in      = {q_r.shreg[6:0], q_r.sdi_s[1]};
			q_nxt.shreg  = byte_in;
			q_nxt.bitc   = q_r.bitc + 1'b1;
			q_nxt.out_sh = {q_r.out_sh[6:0], 1'b0};
			if (q_r.bitc == 3'd0 && q_r.data_ph && !q_r.wr) begin
				// The loaded byte is being clocked out, so it now counts as returned.
				fifo_pop = (q_r.addr == ADDR_FIFO_PORT) && q_r.port_ok; // [RQ15]
				rd_clr1  = (q_r.addr == ADDR_STATUS_ONE); // [RQ11]
				rd_clr2  = (q_r.addr == ADDR_STATUS_TWO);
			end
			if (q_r.bitc == 3'd7) begin
				nxt_addr = (q_r.addr == ADDR_FIFO_PORT) ? q_r.addr : q_r.addr + 1'b1;
				if (!q_r.data_ph) begin
					q_nxt.data_ph = 1'b1;
					q_nxt.wr      = byte_in[7];
					q_nxt.addr    = byte_in[6:0];
				end else begin
					q_nxt.addr = nxt_addr;
					if (q_r.wr && q_r.swrst_cnt == '0) begin
						case (q_r.addr)
							ADDR_ENABLE_ONE: q_nxt.en1      = byte_in;
							ADDR_ENABLE_TWO: q_nxt.en2      = byte_in;
							ADDR_OPFUNC_TWO: q_nxt.ctl2     = byte_in & OPFUNC_MASK;
							ADDR_PRE_THR:    q_nxt.pre_thr  = byte_in;
							ADDR_INV_TIME:   q_nxt.inv_time = byte_in;
							ADDR_FIFO_CTL:   q_nxt.fifo_ctl = byte_in & FIFO_CTL_MASK;
							default:         q_nxt.en1      = q_r.en1;
						endcase
						if (q_r.addr == ADDR_OPFUNC_TWO && byte_in[BIT_SWRST]) begin
							q_nxt.swrst_cnt = 16'(SWRST_CYCLES); // [RQ13]
						end
					end
				end
				if (!(q_r.data_ph ? q_r.wr : byte_in[7])) begin
					// Each read byte loads the next word; nothing is consumed until it is clocked out.
					q_nxt.out_sh  = reg_rd(q_nxt.addr, q_r, fifo_head); // [RQ1]
					q_nxt.port_ok = !fifo_empty;
				end
			end
		end

		// Preamble run length and the invalid-preamble window, both in bit periods.
		if (rx_search_restart) begin
			q_nxt.pre_run     = '0;
			q_nxt.inv_cnt     = '0;
			q_nxt.pre_valid   = 1'b0;
			q_nxt.pre_invalid = 1'b0;
		end else if (rx_bit_tick) begin
			q_nxt.pre_run = rx_preamble_bit ? ((q_r.pre_run == 8'hff) ? q_r.pre_run
			                                   : q_r.pre_run + 1'b1) : 8'h00;
			if (!q_r.pre_valid && rx_preamble_bit && q_nxt.pre_run >= q_r.pre_thr) begin
				q_nxt.pre_valid = 1'b1; // [RQ6]
				set2[BIT_PRE_VALID] = 1'b1; // [RQ11]
			end
			if (q_r.inv_cnt != 6'h3f) begin
				q_nxt.inv_cnt = q_r.inv_cnt + 1'b1;
			end
			if (!q_r.pre_valid && !q_nxt.pre_valid && !q_r.pre_invalid && win != '0
			    && q_nxt.inv_cnt == win) begin
				q_nxt.pre_invalid = 1'b1; // [RQ9]
				set2[BIT_PRE_INVALID] = 1'b1; // [RQ11]
			end
		end

		set1[BIT_ALMOST_FULL] = (fifo_level >= {1'b0, q_r.fifo_ctl[5:0]}); // [RQ2]
		// A status read clears only the bits it reported; a new event in the same cycle survives.
		q_nxt.st1 = (q_r.st1 & ~(rd_clr1 ? q_r.out_sh : 8'h00)) | set1; // [RQ5]
		q_nxt.st2 = (q_r.st2 & ~(rd_clr2 ? q_r.out_sh : 8'h00)) | set2;

		if (q_r.swrst_cnt != '0) begin
			q_nxt.swrst_cnt   = q_r.swrst_cnt - 1'b1;
			q_nxt.st1         = 8'h00; // [RQ12]
			q_nxt.st2         = 8'h00;
			q_nxt.en1         = ENABLE_RST;
			q_nxt.en2         = ENABLE_RST;
			q_nxt.ctl2        = OPFUNC_RST;
			q_nxt.pre_thr     = PRE_THR_RST;
			q_nxt.inv_time    = INV_TIME_RST;
			q_nxt.fifo_ctl    = FIFO_CTL_RST;
			q_nxt.pre_run     = '0;
			q_nxt.inv_cnt     = '0;
			q_nxt.pre_valid   = 1'b0;
			q_nxt.pre_invalid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_r          <= '0;
			q_r.sclk_s   <= 3'b000;
			q_r.nsel_s   <= 3'b111;
			q_r.en1      <= ENABLE_RST; // [RQ12]
			q_r.en2      <= ENABLE_RST;
			q_r.ctl2     <= OPFUNC_RST;
			q_r.pre_thr  <= PRE_THR_RST;
			q_r.inv_time <= INV_TIME_RST;
			q_r.fifo_ctl <= FIFO_CTL_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign spi_sdo                 = q_r.out_sh[7];
	assign interrupt_request_pin_n = !(|(q_r.st1 & q_r.en1) || |(q_r.st2 & q_r.en2)); // [RQ5]
	assign sync_detect_en          = q_r.pre_valid; // [RQ14]
	assign preamble_valid          = q_r.pre_valid;
	assign invalid_preamble        = q_r.pre_invalid;
	assign soft_reset_active       = (q_r.swrst_cnt != '0);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_burst_returns: assert property (fifo_pop && !fifo_empty && !fifo_clr |-> q_r.out_sh == fifo_head) // [RQ1]
		else $error("Burst read returned a byte other than the FIFO head.");
	a_almost_full: assert property ((fifo_level >= {1'b0, q_r.fifo_ctl[5:0]}) && !soft_reset_active
		|=> q_r.st1[BIT_ALMOST_FULL]) // [RQ2]
		else $error("Almost-full status missing at threshold.");
	a_ffclr_level: assert property (q_r.ctl2[BIT_FFCLR] |=> fifo_level == 0) // [RQ4]
		else $error("Pointer clear left bytes counted.");
	a_irq_gated: assert property (((q_r.st1 & q_r.en1) == 0 && (q_r.st2 & q_r.en2) == 0)
		|-> interrupt_request_pin_n) // [RQ5]
		else $error("Interrupt pin low with no enabled event.");
	a_pre_threshold: assert property ($rose(q_r.pre_valid) |-> q_r.pre_run >= q_r.pre_thr) // [RQ6]
		else $error("Preamble declared before the threshold.");
	a_inv_window: assert property ($rose(q_r.pre_invalid)
		|-> q_r.inv_cnt == {q_r.inv_time[7:4], 2'b00} && !q_r.pre_valid) // [RQ10]
		else $error("Invalid preamble outside its window.");
	a_status_report: assert property ($rose(q_r.pre_invalid) |-> q_r.st2[BIT_PRE_INVALID]) // [RQ11]
		else $error("Invalid preamble not reported in status.");
	a_swrst_length: assert property ($rose(soft_reset_active)
		|-> q_r.swrst_cnt == 16'(SWRST_CYCLES) ##1 soft_reset_active) // [RQ13]
		else $error("Software reset pulse has the wrong length.");
	a_swrst_count: assert property (soft_reset_active
		|=> q_r.swrst_cnt == $past(q_r.swrst_cnt) - 16'h0001) // [RQ13]
		else $error("Software reset counter skipped or reloaded.");
	a_swrst_defaults: assert property (soft_reset_active |=> q_r.fifo_ctl == FIFO_CTL_RST
		&& q_r.pre_thr == PRE_THR_RST) // [RQ12]
		else $error("Software reset did not restore defaults.");
	a_sync_gate: assert property (!sync_detect_en && !(rx_bit_tick && rx_preamble_bit)
		|=> !sync_detect_en) // [RQ14]
		else $error("Sync detector enabled without a preamble bit.");

	c_pre_valid: cover property ($rose(q_r.pre_valid));
	c_pre_invalid: cover property ($rose(q_r.pre_invalid));
	c_burst_pop: cover property (fifo_pop && !fifo_empty ##[1:200] fifo_pop && !fifo_empty);
	c_swrst: cover property ($rose(soft_reset_active));
endmodule

// file: tb/rxp_host_model.sv
// SPI host model that reaches the register pins of the receive block.
// Assumes mode 0, MSB first, and callers that run on the same clock as the block.
`timescale 1ns/10ps
module rxp_host_model
	import rxp_pkg::*;
(
	input  wire logic clk,
	input  wire logic spi_sdo,
	output logic      spi_sclk,
	output logic      spi_nsel,
	output logic      spi_sdi
);
	localparam int HALF = 8;

	initial begin
		spi_sclk = 1'b0;
		spi_nsel = 1'b1;
		spi_sdi  = 1'b0;
	end

	task automatic sel();
		@(posedge clk) spi_nsel <= 1'b0;
		repeat (HALF) @(posedge clk);
	endtask

	// The data line is flipped on the same clock edge as the release so a stale level never looks like live data.
	task automatic desel();
		repeat (HALF) @(posedge clk);
		spi_nsel <= 1'b1;
		spi_sdi  <= ~spi_sdi;
		repeat (HALF) @(posedge clk);
	endtask

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spi_sdi <= tx[i];
			repeat (HALF) @(posedge clk);
			rx[i] = spi_sdo;
			spi_sclk <= 1'b1;
			repeat (HALF) @(posedge clk);
			spi_sclk <= 1'b0;
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		sel();
		xfer({1'b1, a}, x);
		xfer(d, x);
		desel();
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		logic [7:0] x;
		sel();
		xfer({1'b0, a}, x);
		xfer(8'h00, d);
		desel();
	endtask

	// Drains four bytes in one burst, first byte in the top of q.
	task automatic burst4(output logic [31:0] q);
		logic [7:0] x;
		sel();
		xfer({1'b0, ADDR_FIFO_PORT}, x);
		for (int i = 3; i >= 0; i--) begin
			xfer(8'h00, x);
			q[8*i +: 8] = x;
		end
		desel();
	endtask
endmodule

// file: tb/rxp_rx_fifo_preamble_tb_top.sv
// Self-checking bench for the receive FIFO and preamble qualifier.
// Assumes the host model drives the SPI pins and the bench drives the demodulator strobes.
`timescale 1ns/10ps
module rxp_rx_fifo_preamble_tb_top;
	import rxp_pkg::*;
	localparam int SWRST_SIM = 20;
	logic        clk, rst_n, spi_sclk, spi_nsel, spi_sdi, spi_sdo;
	logic        rx_bit_tick, rx_preamble_bit, rx_search_restart, rx_byte_valid;
	logic [7:0]  rx_byte, d;
	logic        irq_n, sync_en, pre_valid, pre_invalid, sr_active;
	logic [31:0] q;
	int          failures, checks_done, sr_cnt;
	logic [6:0]  ra [8] = '{ADDR_ENABLE_ONE, ADDR_ENABLE_TWO, ADDR_OPFUNC_TWO, ADDR_PRE_THR,
	                        ADDR_INV_TIME, ADDR_FIFO_CTL, ADDR_STATUS_ONE, 7'h10};
	logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'h00, 8'h14, 8'h00, 8'h37, 8'h00, 8'h00};

	rxp_rx_fifo_preamble #(.SWRST_CYCLES(SWRST_SIM)) dut (
		.clk(clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_nsel(spi_nsel),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .rx_bit_tick(rx_bit_tick),
		.rx_preamble_bit(rx_preamble_bit), .rx_search_restart(rx_search_restart),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .interrupt_request_pin_n(irq_n),
		.sync_detect_en(sync_en), .preamble_valid(pre_valid),
		.invalid_preamble(pre_invalid), .soft_reset_active(sr_active));

	rxp_host_model host (.clk(clk), .spi_sdo(spi_sdo), .spi_sclk(spi_sclk),
		.spi_nsel(spi_nsel), .spi_sdi(spi_sdi));

	always #2.5 clk = ~clk;

	always @(posedge clk)
		if (sr_active === 1'b1)
			sr_cnt <= sr_cnt + 1;

	task automatic give_verdict();
		$display("Checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask

	task automatic bchk(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask

	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask

	task automatic chk_defaults();
		for (int i = 0; i < 8; i++)
			rdchk(ra[i], rv[i]);
	endtask

	task automatic push(input logic [7:0] b);
		@(posedge clk) rx_byte <= b;
		rx_byte_valid <= 1'b1;
		@(posedge clk) rx_byte_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic bits(input int n, input logic v);
		repeat (n) begin
			@(posedge clk) rx_bit_tick <= 1'b1;
			rx_preamble_bit <= v;
			@(posedge clk) rx_bit_tick <= 1'b0;
		end
		repeat (3) @(posedge clk);
	endtask

	task automatic restart();
		@(posedge clk) rx_search_restart <= 1'b1;
		@(posedge clk) rx_search_restart <= 1'b0;
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		rx_bit_tick = 1'b0;
		rx_preamble_bit = 1'b0;
		rx_search_restart = 1'b0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		failures = 0;
		checks_done = 0;
		sr_cnt = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		bchk("irq idle", 1'b1, irq_n);
		chk_defaults();
		host.wr(ADDR_STATUS_ONE, 8'hff);
		rdchk(ADDR_STATUS_ONE, 8'h00);
		// A pointer clear must bring back the first byte, which is still stored.
		push(8'h11);
		push(8'h22);
		push(8'h33);
		rdchk(ADDR_FIFO_PORT, 8'h11);
		rdchk(ADDR_FIFO_PORT, 8'h22);
		host.wr(ADDR_OPFUNC_TWO, 8'h02);
		host.wr(ADDR_OPFUNC_TWO, 8'h00);
		rdchk(ADDR_FIFO_PORT, 8'h11);
		rdchk(ADDR_FIFO_PORT, 8'h11);
		host.wr(ADDR_FIFO_CTL, 8'h04);
		host.wr(ADDR_ENABLE_ONE, 8'h10);
		for (int i = 1; i < 4; i++)
			push({4'ha, 4'(i)});
		bchk("irq below level", 1'b1, irq_n);
		push(8'ha4);
		bchk("irq at level", 1'b0, irq_n);
		host.wr(ADDR_ENABLE_ONE, 8'h00);
		bchk("irq masked", 1'b1, irq_n);
		rdchk(ADDR_STATUS_ONE, 8'h10);
		host.burst4(q);
		for (int i = 0; i < 4; i++)
			chk("fifo byte", {4'ha, 4'(i + 1)}, q[8*(3-i) +: 8]);
		rdchk(ADDR_STATUS_ONE, 8'h10);
		rdchk(ADDR_STATUS_ONE, 8'h00);
		host.wr(ADDR_PRE_THR, 8'h14);
		restart();
		bits(19, 1'b1);
		bits(1, 1'b0);
		bits(19, 1'b1);
		bchk("valid early", 1'b0, pre_valid);
		bchk("sync early", 1'b0, sync_en);
		bits(1, 1'b1);
		bchk("valid", 1'b1, pre_valid);
		bchk("sync", 1'b1, sync_en);
		rdchk(ADDR_STATUS_TWO, 8'h40);
		host.wr(ADDR_INV_TIME, 8'h30);
		restart();
		bits(11, 1'b0);
		bchk("invalid early", 1'b0, pre_invalid);
		bits(1, 1'b0);
		bchk("invalid", 1'b1, pre_invalid);
		rdchk(ADDR_STATUS_ONE, 8'h00);
		host.rd(ADDR_STATUS_TWO, d);
		chk("invalid status", 8'h20, d & 8'h20);
		host.wr(ADDR_OPFUNC_TWO, 8'h80);
		for (int i = 0; i < 200 && !(sr_cnt > 0 && sr_active === 1'b0); i++)
			@(posedge clk);
		if (sr_cnt == 0 || sr_active !== 1'b0) begin
			failures++;
			give_verdict();
		end
		chk("reset pulse", 8'(SWRST_SIM), 8'(sr_cnt));
		chk_defaults();
		give_verdict();
	end

	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule
